/* File: verilog/gpl_path.sv */
// Gigabit PHY latency path: GMII side on i_clk, line side on i_line_clk.
// Assumes the MAC drives i_tx_* on i_clk and honours o_tx_ready, and
// line logic on i_line_clk honours o_line_rx_ready.
//
// Behaviour
// - Delimiter, reset or extension symbol reaches line within 84 bit times; the code only raises o_tx_late once one has waited 10 core cycles.
// - Half duplex: carrier sense rises within 244 bit times of line start.
// - Half duplex: carrier sense falls within 244 bit times of line delimiter.
// - Half duplex: collision rises within 244 bit times of line delimiter.
// - Half duplex: collision falls within 244 bit times of line delimiter.
// - Half duplex: carrier sense rises within 16 bit times of transmit enable.
// - Half duplex: carrier sense falls within 16 bit times of enable dropping.
// - Carrier sense assertion and de-assertion take identical latency.
// - Full duplex: receive valid drops within 244 bit times of carrier reset.
// - Line latencies are referenced to the line symbol sampling point.
`timescale 1ns/1ps
`default_nettype none
module gpl_path #(
  parameter int BUF_DEPTH = gpl_pkg::BUF_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_line_clk,
  input wire logic i_tx_en,
  input wire logic i_tx_er,
  input wire logic [gpl_pkg::DATA_W-1:0] i_txd,
  output logic o_tx_ready,
  output logic o_crs,
  output logic o_col,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic [gpl_pkg::DATA_W-1:0] o_rxd,
  input wire logic i_full_duplex,
  output logic o_tx_late,
  output logic o_line_tx_valid,
  input wire logic i_line_tx_ready,
  output logic [gpl_pkg::CODE_W-1:0] o_line_tx_code,
  output logic [gpl_pkg::DATA_W-1:0] o_line_tx_data,
  input wire logic i_line_rx_valid,
  output logic o_line_rx_ready,
  input wire logic [gpl_pkg::CODE_W-1:0] i_line_rx_code,
  input wire logic [gpl_pkg::DATA_W-1:0] i_line_rx_data
);
  import gpl_pkg::*;

  // Core clock state
  // Everything the MAC side sees except o_tx_ready is registered here, so carrier sense,
  // collision and the receive outputs all leave from flip-flops and their
  // latency is fixed at one core clock after the deciding input.
  // The duplex pin and the marker toggle are synchronised inside this
  // struct as well, so one register process serves the whole domain.
  typedef struct packed {
    logic tx_en_prev;
    logic dup_s1;
    logic dup_s2;
    logic carrier;
    logic crs;
    logic col;
    logic rx_dv;
    logic rx_er;
    logic [DATA_W-1:0] rxd;
    logic mk_s1;
    logic mk_s2;
    logic mk_seen;
    logic [1:0] mk_pend;
    logic [LAT_W-1:0] lat;
    logic late;
  } gpl_core_t;

  // Line clock state
  // The symbol register stands in front of the line and holds its word
  // until the line takes it; the toggle reports each marker that has
  // reached this register back to the core domain.
  typedef struct packed {
    logic tx_valid;
    logic [CODE_W-1:0] tx_code;
    logic [DATA_W-1:0] tx_data;
    logic mk_tgl;
  } gpl_line_t;

  gpl_core_t c_q;
  gpl_core_t c_d;
  gpl_line_t l_q;
  gpl_line_t l_d;

  // Glue between classifier, buffer and the two crossings
  // Words are the code above the data byte in both directions.
  logic [CODE_W-1:0] tx_code;
  logic tx_push;
  logic tx_take;
  logic buf_valid;
  logic buf_ready;
  logic [WORD_W-1:0] buf_word;
  logic ltx_valid;
  logic ltx_ready;
  logic [WORD_W-1:0] ltx_word;
  logic rx_valid;
  logic [WORD_W-1:0] rx_word;

  // Symbols that open, extend or close carrier on the line
  function automatic logic is_marker(input logic [CODE_W-1:0] code);
    is_marker = (code == CODE_SSD) || (code == CODE_CSRESET) ||
                (code == CODE_CSEXT) || (code == CODE_CSEXT_ERR);
  endfunction : is_marker

  // Classify each transmit cycle into a line symbol code
  always_comb
  begin
    tx_code = CODE_IDLE;
    if (i_tx_en && !c_q.tx_en_prev)
    begin
      tx_code = CODE_SSD;
    end
    else if (i_tx_en)
    begin
      tx_code = i_tx_er ? CODE_ERR : CODE_DATA;
    end
    else if (i_tx_er)
    begin
      tx_code = (i_txd == EXT_ERR_DATA) ? CODE_CSEXT_ERR : CODE_CSEXT;
    end
    else if (c_q.tx_en_prev)
    begin
      tx_code = CODE_CSRESET;
    end
  end

  // Only frame, extension and closing cycles travel to the line
  // A cycle is taken when the buffer in front of the crossing has room;
  // a refused cycle is held by the MAC and classified again next cycle.
  assign tx_push = i_tx_en || i_tx_er || c_q.tx_en_prev;
  assign tx_take = tx_push && o_tx_ready;

  // Core clock next state
  always_comb
  begin
    logic half;
    logic mk_hit;
    logic mk_push;
    logic [CODE_W-1:0] rcode;
    half = 1'b0;
    mk_hit = 1'b0;
    mk_push = 1'b0;
    rcode = rx_word[WORD_W-1:DATA_W];
    c_d = c_q;
    // Duplex strap from a pin, two flip-flops before use
    c_d.dup_s1 = i_full_duplex;
    c_d.dup_s2 = c_q.dup_s1;
    half = !c_q.dup_s2;
    // Enable history moves only with a taken cycle, so a refused first
    // cycle of a frame is still sent as the start delimiter
    if (!tx_push || tx_take)
    begin
      c_d.tx_en_prev = i_tx_en;
    end
    // Received words arrive once each through the crossing
    if (rx_valid)
    begin
      unique case (rcode)
        CODE_SSD, CODE_DATA:
        begin
          c_d.carrier = 1'b1;
          c_d.rx_dv = 1'b1;
          c_d.rx_er = 1'b0;
          c_d.rxd = rx_word[DATA_W-1:0];
        end
        CODE_ERR:
        begin
          c_d.carrier = 1'b1;
          c_d.rx_dv = 1'b1;
          c_d.rx_er = 1'b1;
          c_d.rxd = rx_word[DATA_W-1:0];
        end
        CODE_CSEXT, CODE_CSEXT_ERR:
        begin
          c_d.carrier = 1'b1;
          c_d.rx_dv = 1'b0;
          c_d.rx_er = 1'b1;
          c_d.rxd = (rcode == CODE_CSEXT) ? EXT_DATA : EXT_ERR_DATA;
        end
        CODE_CSRESET:
        begin
          c_d.carrier = 1'b0;
          c_d.rx_dv = 1'b0;
          c_d.rx_er = 1'b0;
          c_d.rxd = '0;
        end
        default:
        begin
          c_d.carrier = 1'b0;
          c_d.rx_dv = 1'b0;
          c_d.rx_er = 1'b0;
          c_d.rxd = '0;
        end
      endcase
    end
    // Same single register stage for both edges of carrier sense
    c_d.crs = half && (i_tx_en || c_d.carrier);
    c_d.col = half && i_tx_en && c_d.carrier;
    // Watchdog on markers still waiting to reach the line
    // The pending count rises when a marker enters the buffer and falls
    // when its toggle comes back from the line register. The age counter
    // runs while anything is pending and restarts on every return, so it
    // measures the wait since the last return or since the count left zero; the flag stays set until reset.
    c_d.mk_s1 = l_q.mk_tgl;
    c_d.mk_s2 = c_q.mk_s1;
    c_d.mk_seen = c_q.mk_s2;
    mk_hit = (c_q.mk_s2 != c_q.mk_seen);
    mk_push = tx_take && is_marker(tx_code);
    if (mk_push && !mk_hit && (c_q.mk_pend != 2'h3))
    begin
      c_d.mk_pend = c_q.mk_pend + 1'b1;
    end
    else if (mk_hit && !mk_push && (c_q.mk_pend != 2'h0))
    begin
      c_d.mk_pend = c_q.mk_pend - 1'b1;
    end
    if (mk_hit || (c_q.mk_pend == 2'h0))
    begin
      c_d.lat = '0;
    end
    else if (c_q.lat != LAT_MAX)
    begin
      c_d.lat = c_q.lat + 1'b1;
    end
    if (c_q.lat >= TX_LATE_AT)
    begin
      c_d.late = 1'b1;
    end
  end

  // Line clock: present one symbol until the line takes it
  // A new word is loaded in the same edge that the line takes the old
  // one, so back to back symbols leave without a gap. Each marker flips
  // the toggle that the core watchdog follows.
  always_comb
  begin
    l_d = l_q;
    if (l_q.tx_valid && i_line_tx_ready)
    begin
      l_d.tx_valid = 1'b0;
    end
    if (ltx_valid && ltx_ready)
    begin
      l_d.tx_valid = 1'b1;
      l_d.tx_code = ltx_word[WORD_W-1:DATA_W];
      l_d.tx_data = ltx_word[DATA_W-1:0];
      if (is_marker(ltx_word[WORD_W-1:DATA_W]))
      begin
        l_d.mk_tgl = ~l_q.mk_tgl;
      end
    end
  end

  assign ltx_ready = !l_q.tx_valid || i_line_tx_ready;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  always_ff @(posedge i_line_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      l_q <= '0;
    else
      l_q <= l_d;
  end

  // Two-entry buffer absorbs stalls of the transmit crossing
  // Its ready flag is the MAC's ready, so a full buffer refuses the cycle
  // rather than losing it while the crossing waits for its acknowledge.
  gpl_buf2 #(
    .W(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_tx_buf (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(tx_push),
    .o_in_ready(o_tx_ready),
    .i_in_data({tx_code, i_txd}),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_ready),
    .o_out_data(buf_word)
  );

  // Transmit crossing from the core clock to the line clock
  // The word is held at the source until the acknowledge returns, so
  // only the request toggle needs synchronising on the far side.
  gpl_cdc #(
    .W(WORD_W)
  ) u_tx_cdc (
    .i_resetn(i_resetn),
    .i_s_clk(i_clk),
    .i_s_valid(buf_valid),
    .o_s_ready(buf_ready),
    .i_s_data(buf_word),
    .i_d_clk(i_line_clk),
    .o_d_valid(ltx_valid),
    .i_d_ready(ltx_ready),
    .o_d_data(ltx_word)
  );

  // Received line symbols are taken at the line sampling point
  // The core side always accepts, so each received word appears as a
  // single valid cycle that the next-state logic must use at once.
  gpl_cdc #(
    .W(WORD_W)
  ) u_rx_cdc (
    .i_resetn(i_resetn),
    .i_s_clk(i_line_clk),
    .i_s_valid(i_line_rx_valid),
    .o_s_ready(o_line_rx_ready),
    .i_s_data({i_line_rx_code, i_line_rx_data}),
    .i_d_clk(i_clk),
    .o_d_valid(rx_valid),
    .i_d_ready(1'b1),
    .o_d_data(rx_word)
  );

  // Outputs straight from registers
  // No output passes through logic after its flip-flop, which keeps the
  // interface timing independent of the decoding above.
  assign o_crs = c_q.crs;
  assign o_col = c_q.col;
  assign o_rx_dv = c_q.rx_dv;
  assign o_rx_er = c_q.rx_er;
  assign o_rxd = c_q.rxd;
  assign o_tx_late = c_q.late;
  assign o_line_tx_valid = l_q.tx_valid;
  assign o_line_tx_code = l_q.tx_code;
  assign o_line_tx_data = l_q.tx_data;
endmodule : gpl_path
`default_nettype wire

/* File: verilog/gpl_pkg.sv */
// Constants shared by the gigabit line latency path.
// Assumes one bit time is 1 ns and the core clock runs at 125 MHz.
`default_nettype none
package gpl_pkg;
  // Word layout on both data paths: code above data
  localparam int DATA_W = 8;
  localparam int CODE_W = 3;
  localparam int WORD_W = CODE_W + DATA_W;
  // Bit time and core clock period in picoseconds
  localparam int BIT_PS = 1000;
  localparam int CLK_PS = 8000;
  localparam int BT_PER_CLK = CLK_PS / BIT_PS;
  // Latency budgets in bit times, longest times round down to cycles
  localparam int TX_LINE_BT = 84;
  localparam int TX_LINE_CYC = TX_LINE_BT / BT_PER_CLK;
  localparam int LINE_GMII_BT = 244;
  localparam int LINE_GMII_CYC = LINE_GMII_BT / BT_PER_CLK;
  localparam int TX_CRS_BT = 16;
  localparam int TX_CRS_CYC = TX_CRS_BT / BT_PER_CLK;
  // Latency watchdog counter
  localparam int LAT_W = 6;
  localparam logic [LAT_W-1:0] TX_LATE_AT = LAT_W'(TX_LINE_CYC);
  localparam logic [LAT_W-1:0] LAT_MAX = 6'h3F;
  // Line symbol codes
  localparam logic [CODE_W-1:0] CODE_IDLE = 3'h0;
  localparam logic [CODE_W-1:0] CODE_SSD = 3'h1;
  localparam logic [CODE_W-1:0] CODE_DATA = 3'h2;
  localparam logic [CODE_W-1:0] CODE_CSRESET = 3'h3;
  localparam logic [CODE_W-1:0] CODE_CSEXT = 3'h4;
  localparam logic [CODE_W-1:0] CODE_CSEXT_ERR = 3'h5;
  localparam logic [CODE_W-1:0] CODE_ERR = 3'h6;
  // Data values that mark carrier extension on the MAC side
  localparam logic [DATA_W-1:0] EXT_DATA = 8'h0F;
  localparam logic [DATA_W-1:0] EXT_ERR_DATA = 8'h1F;
  // Buffer depth in front of the transmit crossing
  localparam int BUF_DEPTH = 2;
endpackage : gpl_pkg
`default_nettype wire

/* File: verilog/gpl_buf2.sv */
// Small FIFO with valid and ready on both sides.
// Assumes a single clock; input and output handshakes on that clock.
`timescale 1ns/1ps
`default_nettype none
module gpl_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic ready;
    logic valid;
  } gpl_buf_t;

  gpl_buf_t q;
  gpl_buf_t d;

  // Next index with wrap at the last entry
  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction : nxt

  // Push, pop and registered full and empty flags
  always_comb
  begin
    logic push;
    logic pop;
    push = i_in_valid && q.ready;
    pop = q.valid && i_out_ready;
    d = q;
    if (push)
    begin
      d.mem[q.wr] = i_in_data;
      d.wr = nxt(q.wr);
    end
    if (pop)
    begin
      d.rd = nxt(q.rd);
    end
    if (push && !pop)
    begin
      d.cnt = q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      d.cnt = q.cnt - 1'b1;
    end
    d.ready = (d.cnt != FULL_CNT);
    d.valid = (d.cnt != '0);
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      q <= '0;
    else
      q <= d;
  end

  assign o_in_ready = q.ready;
  assign o_out_valid = q.valid;
  assign o_out_data = q.mem[q.rd];
endmodule : gpl_buf2
`default_nettype wire

/* File: verilog/gpl_cdc.sv */
// Word crossing between two clocks by a toggle request and acknowledge.
// Assumes the source holds its word until the acknowledge returns.
`timescale 1ns/1ps
`default_nettype none
module gpl_cdc #(
  parameter int W = 8
) (
  input wire logic i_resetn,
  input wire logic i_s_clk,
  input wire logic i_s_valid,
  output logic o_s_ready,
  input wire logic [W-1:0] i_s_data,
  input wire logic i_d_clk,
  output logic o_d_valid,
  input wire logic i_d_ready,
  output logic [W-1:0] o_d_data
);
  typedef struct packed {
    logic req;
    logic ready;
    logic [W-1:0] data;
    logic ack_s1;
    logic ack_s2;
  } gpl_src_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
    logic valid;
    logic [W-1:0] data;
  } gpl_dst_t;

  gpl_src_t s_q;
  gpl_src_t s_d;
  gpl_dst_t d_q;
  gpl_dst_t d_d;

  // Source: take a word, toggle the request, wait for the acknowledge
  always_comb
  begin
    s_d = s_q;
    s_d.ack_s1 = d_q.ack;
    s_d.ack_s2 = s_q.ack_s1;
    if (i_s_valid && s_q.ready)
    begin
      s_d.req = ~s_q.req;
      s_d.data = i_s_data;
      s_d.ready = 1'b0;
    end
    else
    begin
      s_d.ready = (s_q.ack_s2 == s_q.req);
    end
  end

  // Destination: capture the held word on a new request
  always_comb
  begin
    d_d = d_q;
    d_d.req_s1 = s_q.req;
    d_d.req_s2 = d_q.req_s1;
    if (d_q.valid && i_d_ready)
      d_d.valid = 1'b0;
    if ((!d_q.valid || i_d_ready) && (d_q.req_s2 != d_q.ack))
    begin
      d_d.valid = 1'b1;
      d_d.data = s_q.data;
      d_d.ack = ~d_q.ack;
    end
  end

  always_ff @(posedge i_s_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  always_ff @(posedge i_d_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      d_q <= '0;
    else
      d_q <= d_d;
  end

  assign o_s_ready = s_q.ready;
  assign o_d_valid = d_q.valid;
  assign o_d_data = d_q.data;
endmodule : gpl_cdc
`default_nettype wire

/* File: verif/gpl_path_checker.sv */
// Checker for the gigabit line latency path, bound to gpl_path.
// Assumes line receive delays count from the take edge on i_line_clk.
`timescale 1ns/1ps
`default_nettype none
module gpl_path_checker #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_line_clk,
  input wire logic i_tx_en,
  input wire logic i_tx_er,
  input wire logic [gpl_pkg::DATA_W-1:0] i_txd,
  input wire logic o_tx_ready,
  input wire logic o_crs,
  input wire logic o_col,
  input wire logic o_rx_dv,
  input wire logic o_rx_er,
  input wire logic [gpl_pkg::DATA_W-1:0] o_rxd,
  input wire logic i_full_duplex,
  input wire logic o_tx_late,
  input wire logic o_line_tx_valid,
  input wire logic i_line_tx_ready,
  input wire logic [gpl_pkg::CODE_W-1:0] o_line_tx_code,
  input wire logic [gpl_pkg::DATA_W-1:0] o_line_tx_data,
  input wire logic i_line_rx_valid,
  input wire logic o_line_rx_ready,
  input wire logic [gpl_pkg::CODE_W-1:0] i_line_rx_code,
  input wire logic [gpl_pkg::DATA_W-1:0] i_line_rx_data
);
  import gpl_pkg::*;
  localparam int LG = 30;
  logic ssd_t, rst_t, ssd_p, rst_p, ssd_ev, rst_ev, hd, fd;
  logic [2:0] fd_s;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Toggle on each received delimiter at its take edge
  always_ff @(posedge i_line_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ssd_t <= 1'b0;
      rst_t <= 1'b0;
    end
    else if (i_line_rx_valid && o_line_rx_ready)
    begin
      ssd_t <= ssd_t ^ (i_line_rx_code == CODE_SSD);
      rst_t <= rst_t ^ (i_line_rx_code == CODE_CSRESET);
    end
  end
  // Event pulses and settled duplex mode in the core domain
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ssd_p <= 1'b0;
      rst_p <= 1'b0;
      fd_s <= 3'h5;
    end
    else
    begin
      ssd_p <= ssd_t;
      rst_p <= rst_t;
      fd_s <= {fd_s[1:0], i_full_duplex};
    end
  end
  assign ssd_ev = ssd_t != ssd_p;
  assign rst_ev = rst_t != rst_p;
  assign hd = fd_s == 3'h0 && !i_full_duplex;
  assign fd = fd_s == 3'h7 && i_full_duplex;
  a_late_sticky:
    assert property (o_tx_late |=> o_tx_late)
    else $error("Late flag cleared without reset");
  a_rx_crs_rise:
    assert property (ssd_ev && hd |-> ##[1:LG] o_crs)
    else $error("Carrier sense late after line start");
  a_rx_crs_fall:
    assert property (rst_ev && hd && !i_tx_en |-> ##[1:LG] !o_crs)
    else $error("Carrier sense stuck after carrier reset");
  a_rx_col_rise:
    assert property (ssd_ev && hd && i_tx_en |-> ##[1:LG] o_col)
    else $error("Collision late after line start");
  a_rx_col_fall:
    assert property (rst_ev && hd |-> ##[1:LG] !o_col)
    else $error("Collision stuck after carrier reset");
  a_crs_tx_rise:
    assert property (hd && $rose(i_tx_en) |-> ##[1:2] o_crs)
    else $error("Carrier sense late after enable");
  a_crs_tx_fall:
    assert property (hd && $fell(i_tx_en) && !i_tx_er && !o_rx_dv
      && !o_rx_er |-> ##[1:2] !o_crs)
    else $error("Carrier sense late to drop");
  a_crs_same_lat:
    assert property (hd && $changed(i_tx_en) && !i_tx_er && !o_rx_dv
      && !o_rx_er && !o_col |=> o_crs == $past(i_tx_en))
    else $error("Carrier sense latency differs by edge");
  a_rx_dv_fall:
    assert property (rst_ev && fd |-> ##[1:LG] !o_rx_dv)
    else $error("Receive valid stuck after carrier reset");
  a_full_quiet:
    assert property (fd && $past(fd) |-> !o_crs && !o_col)
    else $error("Carrier or collision in full duplex");
  c_rx_col: cover property (ssd_ev && hd && i_tx_en);
  c_rx_full: cover property (rst_ev && fd);
  c_tx_stall: cover property ($fell(o_tx_ready));
endmodule : gpl_path_checker
bind gpl_path gpl_path_checker #(.BUF_DEPTH(BUF_DEPTH)) chk_u (.*);
`default_nettype wire

/* File: verif/gpl_line_model.sv */
// Line side partner: takes transmit symbols, offers received ones.
// Assumes the bench fills rx_q and reads tx_q by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module gpl_line_model (
  input wire logic i_line_clk,
  input wire logic i_resetn,
  input wire logic i_stall,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [gpl_pkg::WORD_W-1:0] i_tx_word,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [gpl_pkg::WORD_W-1:0] o_rx_word
);
  import gpl_pkg::*;
  logic [WORD_W-1:0] rx_q[$];
  logic [WORD_W-1:0] tx_q[$];
  // Symbol exchange; an offer holds until taken
  always @(posedge i_line_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_tx_ready <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_word <= 11'h000;
    end
    else
    begin
      if (i_tx_valid && o_tx_ready)
        tx_q.push_back(i_tx_word);
      o_tx_ready <= !i_stall;
      if (!o_rx_valid || i_rx_ready)
      begin
        o_rx_valid <= rx_q.size() > 0;
        if (rx_q.size() > 0)
          o_rx_word <= rx_q.pop_front();
        else
          o_rx_word <= ~o_rx_word; // Released lines keep moving
      end
    end
  end
endmodule : gpl_line_model
`default_nettype wire

/* File: verif/gpl_path_tb_top.sv */
// Testbench for gpl_path: MAC side driven here, line side by the model.
// Assumes a 125 MHz core clock and an unrelated 32 ns line clock.
`timescale 1ns/1ps
`default_nettype none
module gpl_path_tb_top;
  import gpl_pkg::*;
  logic i_clk, i_line_clk, i_resetn, tx_en, tx_er, fd, stall, stall_on;
  logic crs_chk, last_en, en_d, drv_en, saw_full;
  logic tx_rdy, crs, col, rx_dv, rx_er, late, ltv, ltr, lrv, lrr;
  logic [DATA_W-1:0] txd, rxd, ltd;
  logic [CODE_W-1:0] ltc;
  logic [15:0] lfsr;
  logic [WORD_W-1:0] rx_w;
  logic [WORD_W-1:0] exp_q[$];
  int fail_count, checks_done;
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial
  begin
    i_line_clk = 1'b0;
    #3.3;
    forever #16 i_line_clk = ~i_line_clk;
  end
  gpl_path dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_line_clk(i_line_clk), .i_tx_en(tx_en), .i_tx_er(tx_er),
    .i_txd(txd), .o_tx_ready(tx_rdy), .o_crs(crs), .o_col(col),
    .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_rxd(rxd), .i_full_duplex(fd),
    .o_tx_late(late), .o_line_tx_valid(ltv), .i_line_tx_ready(ltr),
    .o_line_tx_code(ltc), .o_line_tx_data(ltd), .i_line_rx_valid(lrv),
    .o_line_rx_ready(lrr), .i_line_rx_code(rx_w[10:8]),
    .i_line_rx_data(rx_w[7:0]));
  gpl_line_model line_u (.i_line_clk(i_line_clk), .i_resetn(i_resetn),
    .i_stall(stall), .i_tx_valid(ltv), .o_tx_ready(ltr),
    .i_tx_word({ltc, ltd}), .o_rx_valid(lrv), .i_rx_ready(lrr),
    .o_rx_word(rx_w));
  function automatic logic [15:0] lfsr_nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_nx
  // Expected line code of a taken transmit cycle
  function automatic logic [CODE_W-1:0] code_of(input logic en, er, le,
    input logic [DATA_W-1:0] d);
    if (en)
      return !le ? CODE_SSD : (er ? CODE_ERR : CODE_DATA);
    return er ? (d == EXT_ERR_DATA ? CODE_CSEXT_ERR : CODE_CSEXT)
      : CODE_CSRESET;
  endfunction : code_of
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task tmo;
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask : tmo
  // Stall pattern, carrier model and expected transmit words
  always @(posedge i_clk)
  begin
    lfsr <= lfsr_nx(lfsr);
    stall <= stall_on & lfsr[0];
    if (stall_on && tx_rdy === 1'b0)
      saw_full <= 1'b1;
    if (crs_chk)
      check(crs, en_d);
    en_d <= tx_en & !fd;
    if ((tx_en | tx_er | last_en) && tx_rdy === 1'b1)
    begin
      exp_q.push_back({code_of(tx_en, tx_er, last_en, txd), txd});
      last_en <= tx_en;
    end
  end
  // One MAC cycle, held while refused
  task automatic tx_cycle(input logic en, er, input logic [7:0] d);
    int k;
    tx_en <= en;
    tx_er <= er;
    txd <= d;
    for (k = 0; k < 300; k++)
    begin
      @(posedge i_clk);
      if (!(en | er | drv_en) || tx_rdy === 1'b1)
        break;
    end
    if (k == 300)
      tmo();
    drv_en = en;
  endtask : tx_cycle
  task automatic frame(input int n, ext, input logic er1);
    for (int i = 0; i < n; i++)
      tx_cycle(1'b1, er1 && i == 2, lfsr[7:0]);
    for (int i = 0; i < ext; i++)
      tx_cycle(1'b0, 1'b1, i == ext - 1 ? EXT_ERR_DATA : EXT_DATA);
    tx_cycle(1'b0, 1'b0, 8'h00);
  endtask : frame
  // Wait for the line to drain, then compare every symbol
  task automatic drain;
    int k;
    logic [WORD_W-1:0] g, e;
    stall_on <= 1'b0;
    for (k = 0; k < 3000 && line_u.tx_q.size() < exp_q.size(); k++)
      @(posedge i_clk);
    if (k == 3000)
      tmo();
    repeat (40) @(posedge i_clk);
    check(8'(line_u.tx_q.size()), 8'(exp_q.size()));
    while (exp_q.size() > 0 && line_u.tx_q.size() > 0)
    begin
      e = exp_q.pop_front();
      g = line_u.tx_q.pop_front();
      check(8'(g[10:8]), 8'(e[10:8]));
      if (e[10:8] == CODE_DATA)
        check(g[7:0], e[7:0]);
    end
  endtask : drain
  task automatic rx_sym(input logic [CODE_W-1:0] c, input logic dv, cs, cl);
    int k;
    logic [DATA_W-1:0] dd;
    dd = lfsr[7:0];
    line_u.rx_q.push_back({c, dd});
    for (k = 0; k < 60 && rx_dv !== dv; k++)
      @(posedge i_clk);
    if (k == 60)
      tmo();
    check(rx_dv, dv);
    check(crs, cs);
    check(col, cl);
    check(rxd, dv ? dd : 8'h00);
    check(rx_er, 1'b0);
  endtask : rx_sym
  // Main sequence
  initial
  begin
    i_resetn = 1'b0;
    {tx_en, tx_er, fd, stall, stall_on, crs_chk} = 6'h00;
    {last_en, en_d, drv_en, saw_full} = 4'h0;
    txd = 8'h00;
    lfsr = 16'h0035;
    fail_count = 0;
    checks_done = 0;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
    crs_chk <= 1'b1;
    frame(6, 0, 1'b0);
    stall_on <= 1'b1;
    frame(12, 0, 1'b1);
    drain();
    check(saw_full, 1'b1);
    check(late, 1'b1);
    crs_chk <= 1'b0;
    rx_sym(CODE_SSD, 1'b1, 1'b1, 1'b0);
    rx_sym(CODE_CSRESET, 1'b0, 1'b0, 1'b0);
    tx_cycle(1'b1, 1'b0, 8'h55);
    rx_sym(CODE_SSD, 1'b1, 1'b1, 1'b1);
    rx_sym(CODE_CSRESET, 1'b0, 1'b1, 1'b0);
    tx_cycle(1'b0, 1'b0, 8'h00);
    repeat (2) @(posedge i_clk);
    check(crs, 1'b0);
    crs_chk <= 1'b1;
    drain();
    crs_chk <= 1'b0;
    fd <= 1'b1;
    repeat (6) @(posedge i_clk);
    crs_chk <= 1'b1;
    rx_sym(CODE_SSD, 1'b1, 1'b0, 1'b0);
    frame(5, 3, 1'b0);
    rx_sym(CODE_CSRESET, 1'b0, 1'b0, 1'b0);
    drain();
    stop_test();
  end
endmodule : gpl_path_tb_top
`default_nettype wire
